// ==== hdl/fgtc_config_regs.v ====
// Purpose : config register group for fan speed, general io and min-temp control
// Assumes : byte register port, inputs synchronous to I_SYS_CLK
// Notes   : lock and pwm mode arrive from the neighbouring config register
//           software reset reloads even while locked; op points keep their value
`timescale 1ns/1ps
`include "fgtc_defines.vh"

// ============================================================
// top module
module fgtc_config_regs #(
  parameter TEMP_W = 8 // temperature code width
) (
  // clock, reset, enable
  input  wire              I_SYS_CLK,
  input  wire              I_RST_N,
  input  wire              I_CE,
  input  wire              I_SW_RESET,
  // register port
  input  wire [7:0]        I_REG_ADDR,
  input  wire              I_REG_WR,
  input  wire              I_REG_RD,
  input  wire [7:0]        I_REG_WDATA,
  output reg  [7:0]        O_REG_RDATA,
  output reg               O_REG_HIT,
  // device wide state
  input  wire              I_LOCK,
  input  wire              I_PWM_HIGH_FREQ,
  // thermal alert pins, active low, asserted by outside source
  input  wire              I_THERMAL_ALERT_PIN_1_N,
  input  wire              I_THERMAL_ALERT_PIN_2_N,
  // remote channel temperatures and operating point programming
  input  wire [TEMP_W-1:0] I_REMOTE1_TEMP,
  input  wire [TEMP_W-1:0] I_REMOTE2_TEMP,
  input  wire              I_OP1_WR,
  input  wire              I_OP2_WR,
  input  wire [TEMP_W-1:0] I_OP_WDATA,
  output reg  [TEMP_W-1:0] O_OP1_POINT,
  output reg  [TEMP_W-1:0] O_OP2_POINT,
  // fan measurement control
  output reg  [3:0]        O_CONTINUOUS_PAIR,
  output reg  [3:0]        O_STRETCH_PAIR,
  output reg  [3:0]        O_PWM_SYNC_PAIR,
  output reg  [1:0]        O_DYN_MIN_TEMP_EN,
  // general io lines
  input  wire [7:0]        I_IO_PIN,
  input  wire [7:0]        I_IO_LOGIC_OUT,
  output reg  [7:0]        O_IO_PIN,
  output reg  [7:0]        O_IO_OE,
  output reg  [7:0]        O_IO_LOGIC_IN
);

  // ============================================================
  // storage
  // four bytes of plain flops; a memory macro would cost more than it saves
  reg  [7:0]        speed_cfg;     // continuous measure pairs
  reg  [7:0]        io_low;        // lines 1-4 pol/dir pairs
  reg  [7:0]        io_high;       // lines 5-8 pol/dir pairs
  reg  [7:0]        dyn_ctrl;      // dynamic min-temp control
  reg               thermal_alert_pin_1_prev;   // for edge detect of pin 1
  reg               thermal_alert_pin_2_prev;   // for edge detect of pin 2
  wire [TEMP_W-1:0] op1_value;     // channel 1 operating point
  wire [TEMP_W-1:0] op2_value;     // channel 2 operating point
  wire              can_write;     // write allowed when unlocked
  wire              thermal_alert_pin_1_event;  // pin 1 newly asserted
  wire              thermal_alert_pin_2_event;  // pin 2 newly asserted
  wire              trig1;         // latch request channel 1
  wire              trig2;         // latch request channel 2
  wire [15:0]       io_cfg;        // both io registers joined
  wire [7:0]        io_pol;        // polarity per line
  wire [7:0]        io_dir;        // direction per line
  reg  [7:0]        next_rdata;    // read mux
  reg               next_hit;      // address decode result
  integer           k;             // loop index

  // ============================================================
  // helpers
  // line index counts from 0, so line 1 sits at bits 1:0
  // polarity bit of a line from its register pair
  function pol_bit;
    input [15:0] cfg;
    input integer line;
    begin
      pol_bit = cfg[2*line];
    end
  endfunction

  // direction bit of a line, next to its polarity bit
  function dir_bit;
    input [15:0] cfg;
    input integer line;
    begin
      dir_bit = cfg[2*line+1];
    end
  endfunction

  // pair bits act only in low-frequency mode; high frequency forces zero
  function [3:0] lf_only;
    input       high_freq;
    input [3:0] bits;
    begin
      lf_only = high_freq ? 4'h0 : bits;
    end
  endfunction

  // logic level to or from pin level; polarity 0 means active low
  function pol_map;
    input level;
    input pol;
    begin
      pol_map = level ~^ pol;
    end
  endfunction

  // lock freezes the four config bytes against host writes once set; only power cycle clears it upstream
  // the lock bit is write-once in its own register, so nothing here
  // ever needs to clear it; a refused write is simply dropped
  assign can_write = I_REG_WR && !I_LOCK;

  // ============================================================
  // configuration registers
  // one process owns all four bytes, so software reset and a host write
  // can never fight over a register
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      speed_cfg <= `FGTC_RST_SPEED_CFG;
      io_low    <= `FGTC_RST_IO_LOW;
      io_high   <= `FGTC_RST_IO_HIGH;
      dyn_ctrl  <= `FGTC_RST_DYN_CTRL;
    end else if (I_CE) begin
      if (I_SW_RESET) begin
        // software reset gives same values as power-on
        // lock does not hold back the reload; only host writes are refused
        speed_cfg <= `FGTC_RST_SPEED_CFG;
        io_low    <= `FGTC_RST_IO_LOW;
        io_high   <= `FGTC_RST_IO_HIGH;
        dyn_ctrl  <= `FGTC_RST_DYN_CTRL;
      end else if (can_write) begin
        case (I_REG_ADDR)
          `FGTC_ADDR_SPEED_CFG: begin
            // upper nibble stays zero, reads back as zero
            speed_cfg <= I_REG_WDATA & `FGTC_SPEED_WR_MASK;
          end
          `FGTC_ADDR_IO_LOW: begin
            io_low <= I_REG_WDATA;
          end
          `FGTC_ADDR_IO_HIGH: begin
            io_high <= I_REG_WDATA;
          end
          `FGTC_ADDR_DYN_CTRL: begin
            // reserved 7:6 kept read/write as printed
            dyn_ctrl <= I_REG_WDATA;
          end
          default: begin
            // other addresses belong to other blocks
          end
        endcase
      end
    end
  end

  // ============================================================
  // thermal pin edge detect: assertion is a falling edge on the pin
  // prev holds the asserted level, so its reset value 0 matches an idle
  // pin and no false event follows reset
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      thermal_alert_pin_1_prev <= 1'b0;
      thermal_alert_pin_2_prev <= 1'b0;
    end else if (I_CE) begin
      thermal_alert_pin_1_prev <= !I_THERMAL_ALERT_PIN_1_N;
      thermal_alert_pin_2_prev <= !I_THERMAL_ALERT_PIN_2_N;
    end
  end

  // an event lasts one cycle; a pin held low copies nothing more
  assign thermal_alert_pin_1_event = !I_THERMAL_ALERT_PIN_1_N && !thermal_alert_pin_1_prev;
  assign thermal_alert_pin_2_event = !I_THERMAL_ALERT_PIN_2_N && !thermal_alert_pin_2_prev;

  // a cleared latch bit masks the pin for that channel
  // both pins hitting one channel in one cycle still make a single copy
  assign trig1 = (thermal_alert_pin_1_event && dyn_ctrl[`FGTC_PIN1_LATCH_CH1]) ||
                 (thermal_alert_pin_2_event && dyn_ctrl[`FGTC_PIN2_LATCH_CH1]);
  assign trig2 = (thermal_alert_pin_1_event && dyn_ctrl[`FGTC_PIN1_LATCH_CH2]) ||
                 (thermal_alert_pin_2_event && dyn_ctrl[`FGTC_PIN2_LATCH_CH2]);

  // ============================================================
  // operating points, one per remote channel
  // host programming of the points is not lock-gated; the points live
  // outside the lockable set
  fgtc_op_point #(
    .WIDTH   (TEMP_W)
  ) u_op1 (
    .clk     (I_SYS_CLK),
    .rst_n   (I_RST_N),
    .ce      (I_CE),
    .wr      (I_OP1_WR),
    .wr_data (I_OP_WDATA),
    .trig    (trig1),
    .temp    (I_REMOTE1_TEMP),
    .value   (op1_value)
  );

  fgtc_op_point #(
    .WIDTH   (TEMP_W)
  ) u_op2 (
    .clk     (I_SYS_CLK),
    .rst_n   (I_RST_N),
    .ce      (I_CE),
    .wr      (I_OP2_WR),
    .wr_data (I_OP_WDATA),
    .trig    (trig2),
    .temp    (I_REMOTE2_TEMP),
    .value   (op2_value)
  );

  // ============================================================
  // general io decode
  // line n owns bits 2n-2 and 2n-1 of the joined pair
  assign io_cfg = {io_high, io_low};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_io
      assign io_pol[g] = pol_bit(io_cfg, g);
      assign io_dir[g] = dir_bit(io_cfg, g);
    end
  endgenerate

  // ============================================================
  // read mux, unmapped index reads zero with no hit
  // data is captured only on a read strobe, so the host sees a steady
  // byte until its next read even while the registers move on
  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    case (I_REG_ADDR)
      `FGTC_ADDR_SPEED_CFG: next_rdata = speed_cfg;
      `FGTC_ADDR_IO_LOW:    next_rdata = io_low;
      `FGTC_ADDR_IO_HIGH:   next_rdata = io_high;
      `FGTC_ADDR_DYN_CTRL:  next_rdata = dyn_ctrl;
      default:              next_hit   = 1'b0;
    endcase
  end

  // ============================================================
  // registered outputs
  // every output leaves from this one flop stage, a cycle behind the
  // registers; the host must allow for it after a write
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_REG_RDATA       <= 8'h00;
      O_REG_HIT         <= 1'b0;
      O_OP1_POINT       <= {TEMP_W{1'b0}};
      O_OP2_POINT       <= {TEMP_W{1'b0}};
      O_CONTINUOUS_PAIR <= 4'h0;
      O_STRETCH_PAIR    <= 4'h0;
      O_PWM_SYNC_PAIR   <= 4'h0;
      O_DYN_MIN_TEMP_EN <= 2'h0;
      O_IO_PIN          <= 8'h00;
      O_IO_OE           <= 8'h00;
      O_IO_LOGIC_IN     <= 8'h00;
    end else if (I_CE) begin
      // read data held until next read
      if (I_REG_RD) begin
        O_REG_RDATA <= next_rdata;
        O_REG_HIT   <= next_hit;
      end
      O_OP1_POINT <= op1_value;
      O_OP2_POINT <= op2_value;
      // high-frequency mode ignores the continuous bits
      O_CONTINUOUS_PAIR <= lf_only(I_PWM_HIGH_FREQ, speed_cfg[3:0]);
      // stretching and pwm sync only in low frequency, non-continuous pairs
      // sync follows stretch: both stop together when a pair goes continuous
      O_STRETCH_PAIR  <= lf_only(I_PWM_HIGH_FREQ, ~speed_cfg[3:0]);
      O_PWM_SYNC_PAIR <= lf_only(I_PWM_HIGH_FREQ, ~speed_cfg[3:0]);
      // enables pass straight on; the min-temp control loop lives elsewhere
      O_DYN_MIN_TEMP_EN <= {dyn_ctrl[`FGTC_DYN_EN_CH2], dyn_ctrl[`FGTC_DYN_EN_CH1]};
      for (k = 0; k < 8; k = k + 1) begin
        // active low lines invert between pin and logic level
        O_IO_PIN[k]      <= pol_map(I_IO_LOGIC_OUT[k], io_pol[k]);
        O_IO_OE[k]       <= io_dir[k];
        O_IO_LOGIC_IN[k] <= pol_map(I_IO_PIN[k], io_pol[k]);
      end
    end
  end

endmodule // fgtc_config_regs

// ==== hdl/fgtc_defines.vh ====
// Purpose : constants for the fan, general io and dynamic min-temp config registers
// Assumes : byte-wide register port, 8-bit register index
// Notes   : definitions only
`ifndef FGTC_DEFINES_VH
`define FGTC_DEFINES_VH

// ============================================================
// register indices
`define FGTC_ADDR_SPEED_CFG   8'h08
`define FGTC_ADDR_IO_LOW      8'h09
`define FGTC_ADDR_IO_HIGH     8'h0A
`define FGTC_ADDR_DYN_CTRL    8'h0B

// ============================================================
// reset values
`define FGTC_RST_SPEED_CFG    8'h0F
`define FGTC_RST_IO_LOW       8'h00
`define FGTC_RST_IO_HIGH      8'h00
`define FGTC_RST_DYN_CTRL     8'h00

// ============================================================
// field positions and masks
`define FGTC_SPEED_WR_MASK    8'h0F
`define FGTC_DYN_EN_CH1       0
`define FGTC_DYN_EN_CH2       1
`define FGTC_PIN1_LATCH_CH1   2
`define FGTC_PIN1_LATCH_CH2   3
`define FGTC_PIN2_LATCH_CH1   4
`define FGTC_PIN2_LATCH_CH2   5

`endif

// ==== hdl/fgtc_op_point.v ====
// Purpose : one remote channel operating point, latched down on thermal pin events
// Assumes : temperatures are unsigned 8-bit codes
// Notes   : software write wins over a latch in the same cycle
`timescale 1ns/1ps

// ============================================================
// operating point holder
module fgtc_op_point #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // software access
  input  wire             wr,
  input  wire [WIDTH-1:0] wr_data,
  // latch request
  input  wire             trig,
  input  wire [WIDTH-1:0] temp,
  // held value
  output reg  [WIDTH-1:0] value
);

  // copy only when current temperature is below stored point
  always @(posedge clk) begin
    if (!rst_n) begin
      value <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (wr) begin
        value <= wr_data;
      end else if (trig && (temp < value)) begin
        value <= temp;
      end
    end
  end

endmodule // fgtc_op_point

// ==== verif/fgtc_config_regs_bench.sv ====
// Purpose : self-checking bench for the config registers
// Assumes : host model issues one request at a time
// Notes   : integer model predicts every result
`timescale 1ns/1ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
// ====================
// bench
module fgtc_config_regs_bench;
  logic clk = 0, rst_n = 0, swr = 0, lock = 0, pwm = 0, p1_n = 1, p2_n = 1, o1w = 0, o2w = 0;
  logic ce = 1;
  logic [7:0] t1 = 0, t2 = 0, owd = 0, pin = 0, lo = 0, q, a;
  wire  [7:0] addr, wdata, rdata, op1, op2, iout, oe, lin;
  wire        wr, rd, hit;
  wire  [3:0] cont, str, sync;
  wire  [1:0] dyn;
  integer failures = 0, tests_run = 0, seed = 32'h8902D7AF, m[4], mo1, mo2, i, j;
  initial forever #5 clk = ~clk;
  fgtc_host_model u_fgtc_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata));
  fgtc_config_regs u_fgtc_config_regs (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_SW_RESET(swr), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_HIT(hit), .I_LOCK(lock), .I_PWM_HIGH_FREQ(pwm),
    .I_THERMAL_ALERT_PIN_1_N(p1_n), .I_THERMAL_ALERT_PIN_2_N(p2_n), .I_REMOTE1_TEMP(t1),
    .I_REMOTE2_TEMP(t2), .I_OP1_WR(o1w), .I_OP2_WR(o2w), .I_OP_WDATA(owd),
    .O_OP1_POINT(op1), .O_OP2_POINT(op2), .O_CONTINUOUS_PAIR(cont), .O_STRETCH_PAIR(str),
    .O_PWM_SYNC_PAIR(sync), .O_DYN_MIN_TEMP_EN(dyn), .I_IO_PIN(pin), .I_IO_LOGIC_OUT(lo),
    .O_IO_PIN(iout), .O_IO_OE(oe), .O_IO_LOGIC_IN(lin));
  // ====================
  // tasks
  task automatic close_out;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // locked writes leave the model alone
  task automatic wreg(input logic [7:0] ad, d);
    u_fgtc_host_model.xfer(1'b1, ad, d, q);
    if (ce && !lock && ad >= 8 && ad <= 11)
      m[ad-8] = (ad == 8) ? (d & 8'h0F) : d;
  endtask
  task automatic rchk(input logic [7:0] ad);
    logic h;
    h = ad >= 8 && ad <= 11;
    u_fgtc_host_model.xfer(1'b0, ad, 8'h00, q);
    `CK("rdata", h ? 8'(m[ad-8]) : 8'h00, q)
    `CK("hit", h, hit)
  endtask
  // outputs settle two edges after the write
  task automatic outs;
    logic [7:0] pl, dr, r;
    logic [3:0] sc;
    @(posedge clk);
    #1;
    for (int k = 0; k < 8; k++) begin
      r = 8'(m[1 + k / 4]);
      pl[k] = r[2 * (k % 4)];
      dr[k] = r[2 * (k % 4) + 1];
    end
    sc = pwm ? 4'h0 : ~4'(m[0]);
    `CK("cont", pwm ? 4'h0 : 4'(m[0]), cont)
    `CK("stretch", ({sc, sc}), ({str, sync}))
    `CK("oe", dr, oe)
    `CK("io", ({~(lo ^ pl), ~(pin ^ pl)}), ({iout, lin}))
    `CK("dyn", 2'(m[3]), dyn)
    `CK("op", ({8'(mo1), 8'(mo2)}), ({op1, op2}))
  endtask
  // one falling alert on pin p, copy only to a lower point
  task automatic fire(input int p);
    @(posedge clk);
    #1;
    {p1_n, p2_n} = (p == 1) ? 2'b01 : 2'b10;
    if (m[3][2*p] && t1 < mo1) mo1 = t1;
    if (m[3][2*p+1] && t2 < mo2) mo2 = t2;
    repeat (2) @(posedge clk);
    #1;
    {p1_n, p2_n} = 2'b11;
  endtask
  // ====================
  // sequence
  initial begin
    {m[0], m[1], m[2], m[3], mo1, mo2} = {32'd15, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1;
    for (i = 7; i < 13; i++) rchk(8'(i));
    for (i = 0; i < 24; i++) begin
      {pwm, pin, lo} = 17'($random(seed));
      a = 8'(8 + ($random(seed) & 3));
      wreg(a, 8'($random(seed)));
      outs();
      rchk(a);
    end
    wreg(8'h0C, 8'hFF);
    rchk(8'h0C);
    // a frozen block takes no write and holds its outputs
    ce = 0;
    wreg(8'h09, ~8'(m[1]));
    outs();
    ce = 1;
    rchk(8'h09);
    for (j = 0; j < 16; j++) begin
      if (j % 4 == 0) begin
        @(posedge clk);
        #1;
        {o1w, o2w, owd} = 10'h380;
        @(posedge clk);
        #1;
        {o1w, o2w, mo1, mo2} = {2'b00, 32'h80, 32'h80};
      end
      wreg(8'h0B, 8'($random(seed)));
      {t1, t2} = 16'($random(seed));
      fire(j % 2 + 1);
      outs();
    end
    lock = 1;
    for (i = 8; i < 12; i++) wreg(8'(i), 8'hA5);
    for (i = 8; i < 12; i++) rchk(8'(i));
    @(posedge clk);
    #1;
    swr = 1;
    @(posedge clk);
    #1;
    {swr, m[0], m[1], m[2], m[3]} = {1'b0, 32'd15, 32'd0, 32'd0, 32'd0};
    for (i = 8; i < 12; i++) rchk(8'(i));
    outs();
    close_out();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule // fgtc_config_regs_bench

// ==== verif/fgtc_config_regs_checker.sv ====
// Purpose : port assertions for the config register group
// Assumes : one clock, sync active-low reset
// Notes   : bound to the top module at the foot
`timescale 1ns/1ps
// ====================
// checker
module fgtc_config_regs_checker #(parameter TEMP_W = 8) (
  // clock and register port
  input logic              I_SYS_CLK,
  input logic              I_RST_N,
  input logic              I_CE,
  input logic              I_SW_RESET,
  input logic [7:0]        I_REG_ADDR,
  input logic              I_REG_WR,
  input logic              I_REG_RD,
  input logic [7:0]        O_REG_RDATA,
  input logic              O_REG_HIT,
  // device state and outputs
  input logic              I_LOCK,
  input logic              I_PWM_HIGH_FREQ,
  input logic [TEMP_W-1:0] I_REMOTE1_TEMP,
  input logic              I_OP1_WR,
  input logic [TEMP_W-1:0] O_OP1_POINT,
  input logic [3:0]        O_CONTINUOUS_PAIR,
  input logic [3:0]        O_STRETCH_PAIR,
  input logic [7:0]        O_IO_OE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // taken read and soft reload as named steps
  sequence s_rd(a); I_CE && I_REG_RD && I_REG_ADDR == a; endsequence
  sequence s_swr; I_CE && I_SW_RESET && !I_REG_WR; endsequence
  // ====================
  // register port
  property p_rsvd; s_rd(8'h08) |=> O_REG_RDATA[7:4] == 4'h0 && O_REG_HIT; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_unmap; I_CE && I_REG_RD && (I_REG_ADDR < 8'h08 || I_REG_ADDR > 8'h0B)
    |=> !O_REG_HIT && O_REG_RDATA == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read hit");
  property p_swr; s_swr ##1 (I_CE && !I_REG_WR) ##1 s_rd(8'h08) |=> O_REG_RDATA == 8'h0F;
  endproperty
  a_swr: assert property (p_swr) else $error("soft reset value wrong");
  // lock holds the direction bits whatever is written
  property p_lock; (I_LOCK && !I_SW_RESET) [*3] |-> $stable(O_IO_OE); endproperty
  a_lock: assert property (p_lock) else $error("locked register moved");
  // ====================
  // derived outputs
  property p_hf; (I_CE && I_PWM_HIGH_FREQ) [*2]
    |-> O_CONTINUOUS_PAIR == 4'h0 && O_STRETCH_PAIR == 4'h0; endproperty
  a_hf: assert property (p_hf) else $error("pair bits in high freq");
  property p_lf; (I_CE && !I_PWM_HIGH_FREQ) [*2]
    |-> (O_CONTINUOUS_PAIR ^ O_STRETCH_PAIR) == 4'hF; endproperty
  a_lf: assert property (p_lf) else $error("stretch not inverse");
  property p_oe; s_rd(8'h09) |=> O_IO_OE[3:0] ==
    {O_REG_RDATA[7], O_REG_RDATA[5], O_REG_RDATA[3], O_REG_RDATA[1]}; endproperty
  a_oe: assert property (p_oe) else $error("direction mismatch");
  // a latch may only lower the point, to the temperature two cycles back
  property p_op; !$stable(O_OP1_POINT) && !$past(I_OP1_WR, 2) && $past(I_CE)
    && $past(I_CE, 2) |-> O_OP1_POINT <
    $past(O_OP1_POINT) && O_OP1_POINT == $past(I_REMOTE1_TEMP, 2); endproperty
  a_op: assert property (p_op) else $error("bad point latch");
endmodule // fgtc_config_regs_checker
// ====================
// attach
bind fgtc_config_regs fgtc_config_regs_checker #(.TEMP_W(TEMP_W)) u_fgtc_config_regs_checker (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_SW_RESET(I_SW_RESET),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_HIT(O_REG_HIT), .I_LOCK(I_LOCK),
  .I_PWM_HIGH_FREQ(I_PWM_HIGH_FREQ), .I_REMOTE1_TEMP(I_REMOTE1_TEMP), .I_OP1_WR(I_OP1_WR),
  .O_OP1_POINT(O_OP1_POINT), .O_CONTINUOUS_PAIR(O_CONTINUOUS_PAIR),
  .O_STRETCH_PAIR(O_STRETCH_PAIR), .O_IO_OE(O_IO_OE));

// ==== verif/fgtc_host_model.sv ====
// Purpose : host requester for the config registers
// Assumes : one request at a time, just after an edge
// Notes   : released address and data lines show the inverse value; strobes drop to zero
`timescale 1ns/1ps
// ====================
// host
module fgtc_host_model (
  input  logic       clk,   // system clock
  input  logic [7:0] rdata, // read answer
  output logic [7:0] addr,  // register index
  output logic       wr,    // write strobe
  output logic       rd,    // read strobe
  output logic [7:0] wdata  // write data
);
  // idle: no strobe
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // held for exactly one taking edge, answer read just after it
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    #1;
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk);
    #1;
    q = rdata;
    {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // fgtc_host_model
